// *** rtl/crb_pkg.sv ***
// Purpose: Shared constants for the capture/reload/baud timer
// Assumes: Eight-bit register space, 100 MHz system clock
// Notes:   Register offsets, field positions, reset values, divider counts
package crb_pkg;

	// Register offsets in register space
	localparam logic [7:0] CRB_ADDR_MODE_CONTROL = 8'hc9;
	localparam logic [7:0] CRB_ADDR_RELOAD_LOW   = 8'he4;
	localparam logic [7:0] CRB_ADDR_RELOAD_HIGH  = 8'he5;
	localparam logic [7:0] CRB_ADDR_COUNT_LOW    = 8'hf4;
	localparam logic [7:0] CRB_ADDR_COUNT_HIGH   = 8'hf5;

	// Mode control field positions
	localparam int CRB_BIT_OVERFLOW_FLAG  = 7;
	localparam int CRB_BIT_EXTERNAL_FLAG  = 6;
	localparam int CRB_BIT_UART_RX_SELECT = 5;
	localparam int CRB_BIT_UART_TX_SELECT = 4;
	localparam int CRB_BIT_EXT_ENABLE     = 3;
	localparam int CRB_BIT_RUN            = 2;
	localparam int CRB_BIT_COUNTER_SELECT = 1;
	localparam int CRB_BIT_CAPTURE_SELECT = 0;

	// Reset values, counter maximum and step
	localparam logic [7:0]  CRB_RESET_BYTE  = 8'h00;
	localparam logic [15:0] CRB_RESET_WORD  = 16'h0000;
	localparam logic [15:0] CRB_COUNT_MAX   = 16'hffff;
	localparam logic [15:0] CRB_COUNT_STEP  = 16'h0001;

	// System clock dividers
	localparam logic [3:0] CRB_DIV12_LAST   = 4'hb;
	localparam logic [3:0] CRB_DIV_ZERO     = 4'h0;
	localparam logic [3:0] CRB_DIV_STEP     = 4'h1;

	// Operating modes
	typedef enum logic [1:0] {
		CRB_MODE_OFF     = 2'b00,
		CRB_MODE_CAPTURE = 2'b01,
		CRB_MODE_RELOAD  = 2'b10,
		CRB_MODE_BAUD    = 2'b11
	} crb_mode_t;

endpackage

// *** rtl/crb_fall_detect.sv ***
// Purpose: High-to-low transition detector for a synchronous pin
// Assumes: Pin already synchronous to clock_in
// Notes:   Pulse lasts one cycle after the falling edge is seen
`timescale 1ns/100ps
module crb_fall_detect (
	// Clock and reset
	input  wire logic clock_in,
	input  wire logic rst_n_in,
	// Pin and event
	input  wire logic pin_in,
	output logic      fall_out
);
	logic pin_prev;

	// Idle level is high so reset gives no false edge
	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			pin_prev <= 1'b1;
		end else begin
			pin_prev <= pin_in;
		end
	end

	assign fall_out = pin_prev & ~pin_in;
endmodule

// *** rtl/crb_prescaler.sv ***
// Purpose: System clock ticks divided by twelve and by two
// Assumes: Free running from reset
// Notes:   Ticks are one-cycle pulses
`timescale 1ns/100ps
module crb_prescaler
	import crb_pkg::*;
(
	// Clock and reset
	input  wire logic clock_in,
	input  wire logic rst_n_in,
	// Ticks
	output logic      tick_div12_out,
	output logic      tick_div2_out
);
	logic [3:0] div12_count;
	logic       half_phase;

	// Divide by twelve
	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			div12_count <= CRB_DIV_ZERO;
		end else if (div12_count == CRB_DIV12_LAST) begin
			div12_count <= CRB_DIV_ZERO;
		end else begin
			div12_count <= div12_count + CRB_DIV_STEP;
		end
	end

	// Divide by two
	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			half_phase <= 1'b0;
		end else begin
			half_phase <= ~half_phase;
		end
	end

	assign tick_div12_out = (div12_count == CRB_DIV12_LAST);
	assign tick_div2_out  = half_phase;
endmodule

// *** rtl/crb_timer.sv ***
// Purpose: 16-bit capture / auto-reload / baud-rate timer
// Assumes: Register space port with one-cycle strobes; pins synchronous
// Notes:   Read data is registered and valid the cycle after sfr_rd_in
//
// What this block does
// - Counter-select clear, capture or reload mode: count system clock, undivided or divided by 12.
// - Counter-select set: count each falling edge of the count pin.
// - Run clear means off; UART selects mean baud; else capture or reload.
// - Capture mode with external enable: trigger fall copies count to reload pair.
// - Trigger-caused capture or reload sets the external edge flag.
// - Capture and reload modes: rollover from ffff sets overflow flag.
// - External enable clear: trigger pin transitions are ignored.
// - Reload mode: overflow loads reload pair into the counter.
// - Reload mode with external enable: trigger fall forces reload, sets flag.
// - Either UART select set: auto-reload regardless of capture select.
// - Baud mode: overflow reloads, no overflow flag, feeds UART shift clock.
// - Baud mode, counter-select clear: count at half the system clock.
// - Baud mode, counter-select set: count count-pin falling edges.
// - Baud mode with external enable: trigger fall sets external edge flag.
// - Baud ticks serve the second serial port only in its modes 1 or 3.
// - Receive and transmit selects pick this or the other timer's overflows.
// - Flags never cleared by hardware; a set flag requests the interrupt while timer_irq_enable_in is high.
// - Writing run to 1 starts counting; writing 0 stops it.
`timescale 1ns/100ps
module crb_timer
	import crb_pkg::*;
(
	// Clock and reset
	input  wire logic       clock_in,
	input  wire logic       rst_n_in,
	// Register space
	input  wire logic [7:0] sfr_addr_in,
	input  wire logic       sfr_wr_in,
	input  wire logic       sfr_rd_in,
	input  wire logic [7:0] sfr_wdata_in,
	output logic      [7:0] sfr_rdata_out,
	// Clock control and interrupt enable from the core
	input  wire logic       clock_divide_select_in,
	input  wire logic       timer_irq_enable_in,
	output logic            timer_irq_request_out,
	// External pins
	input  wire logic       count_input_pin_in,
	input  wire logic       capture_trigger_pin_in,
	// Second serial port clocking
	input  wire logic       uart_mode_13_in,
	input  wire logic       other_timer_overflow_in,
	output logic            uart_rx_shift_tick_out,
	output logic            uart_tx_shift_tick_out
);
	// Control and flag bits
	logic        overflow_flag;
	logic        external_edge_flag;
	logic        uart_rx_clock_select;
	logic        uart_tx_clock_select;
	logic        external_trigger_enable;
	logic        run_bit;
	logic        counter_select;
	logic        capture_reload_select;

	// Data registers
	logic [15:0] count;
	logic [15:0] reload;

	// Decoded events
	crb_mode_t   mode;
	logic        tick_div12;
	logic        tick_div2;
	logic        count_fall;
	logic        trigger_fall;
	logic        system_clock_tick;
	logic        count_tick;
	logic        rollover;
	logic        trigger_event;
	logic        trigger_capture;
	logic        trigger_reload;
	logic        reload_now;
	logic        baud_overflow;
	logic        set_overflow;
	logic        set_external;

	// Register strobes
	logic        wr_control;
	logic        wr_reload_low;
	logic        wr_reload_high;
	logic        wr_count_low;
	logic        wr_count_high;
	logic [7:0]  control_view;
	logic [7:0]  next_rdata;
	logic [15:0] next_count;
	logic [15:0] next_reload;

	// Tick sources
	crb_prescaler u_prescaler (
		.clock_in       (clock_in),
		.rst_n_in       (rst_n_in),
		.tick_div12_out (tick_div12),
		.tick_div2_out  (tick_div2)
	);

	crb_fall_detect u_count_fall (
		.clock_in (clock_in),
		.rst_n_in (rst_n_in),
		.pin_in   (count_input_pin_in),
		.fall_out (count_fall)
	);

	crb_fall_detect u_trigger_fall (
		.clock_in (clock_in),
		.rst_n_in (rst_n_in),
		.pin_in   (capture_trigger_pin_in),
		.fall_out (trigger_fall)
	);

	// Mode decode
	always_comb begin
		if (!run_bit) begin
			mode = CRB_MODE_OFF;
		end else if (uart_rx_clock_select || uart_tx_clock_select) begin
			mode = CRB_MODE_BAUD;
		end else if (capture_reload_select) begin
			mode = CRB_MODE_CAPTURE;
		end else begin
			mode = CRB_MODE_RELOAD;
		end
	end

	// System clock timebase
	always_comb begin
		case (mode)
			CRB_MODE_BAUD: begin
				system_clock_tick = tick_div2;
			end
			CRB_MODE_CAPTURE,
			CRB_MODE_RELOAD: begin
				system_clock_tick = clock_divide_select_in ? 1'b1 : tick_div12;
			end
			default: begin
				system_clock_tick = 1'b0;
			end
		endcase
	end

	// Count tick and events
	assign count_tick      = (mode != CRB_MODE_OFF)
		&& (counter_select ? count_fall : system_clock_tick);
	assign rollover        = count_tick && (count == CRB_COUNT_MAX);
	assign trigger_event   = (mode != CRB_MODE_OFF) && external_trigger_enable
		&& trigger_fall;
	assign set_external    = trigger_event;

	// Mode-dependent overflow and trigger actions
	always_comb begin
		trigger_capture = 1'b0;
		trigger_reload  = 1'b0;
		reload_now      = 1'b0;
		baud_overflow   = 1'b0;
		set_overflow    = 1'b0;
		case (mode)
			CRB_MODE_CAPTURE: begin
				trigger_capture = trigger_event;
				set_overflow    = rollover;
			end
			CRB_MODE_RELOAD: begin
				trigger_reload  = trigger_event;
				reload_now      = rollover || trigger_event;
				set_overflow    = rollover;
			end
			CRB_MODE_BAUD: begin
				reload_now      = rollover;
				baud_overflow   = rollover;
			end
			default: begin
				reload_now      = 1'b0;
			end
		endcase
	end

	// Register strobes
	assign wr_control     = sfr_wr_in && (sfr_addr_in == CRB_ADDR_MODE_CONTROL);
	assign wr_reload_low  = sfr_wr_in && (sfr_addr_in == CRB_ADDR_RELOAD_LOW);
	assign wr_reload_high = sfr_wr_in && (sfr_addr_in == CRB_ADDR_RELOAD_HIGH);
	assign wr_count_low   = sfr_wr_in && (sfr_addr_in == CRB_ADDR_COUNT_LOW);
	assign wr_count_high  = sfr_wr_in && (sfr_addr_in == CRB_ADDR_COUNT_HIGH);

	// Overflow flag, set wins over software clear
	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			overflow_flag <= 1'b0;
		end else if (set_overflow) begin
			overflow_flag <= 1'b1;
		end else if (wr_control) begin
			overflow_flag <= sfr_wdata_in[CRB_BIT_OVERFLOW_FLAG];
		end
	end

	// External edge flag, set wins over software clear
	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			external_edge_flag <= 1'b0;
		end else if (set_external) begin
			external_edge_flag <= 1'b1;
		end else if (wr_control) begin
			external_edge_flag <= sfr_wdata_in[CRB_BIT_EXTERNAL_FLAG];
		end
	end

	// Control bits
	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			uart_rx_clock_select    <= 1'b0;
			uart_tx_clock_select    <= 1'b0;
			external_trigger_enable <= 1'b0;
			run_bit                 <= 1'b0;
			counter_select          <= 1'b0;
			capture_reload_select   <= 1'b0;
		end else if (wr_control) begin
			uart_rx_clock_select    <= sfr_wdata_in[CRB_BIT_UART_RX_SELECT];
			uart_tx_clock_select    <= sfr_wdata_in[CRB_BIT_UART_TX_SELECT];
			external_trigger_enable <= sfr_wdata_in[CRB_BIT_EXT_ENABLE];
			run_bit                 <= sfr_wdata_in[CRB_BIT_RUN];
			counter_select          <= sfr_wdata_in[CRB_BIT_COUNTER_SELECT];
			capture_reload_select   <= sfr_wdata_in[CRB_BIT_CAPTURE_SELECT];
		end
	end

	// Next counter value; software byte write replaces that byte
	always_comb begin
		next_count = count;
		if (reload_now) begin
			next_count = reload;
		end else if (count_tick) begin
			next_count = count + CRB_COUNT_STEP;
		end
		if (wr_count_low) begin
			next_count[7:0] = sfr_wdata_in;
		end
		if (wr_count_high) begin
			next_count[15:8] = sfr_wdata_in;
		end
	end

	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			count <= CRB_RESET_WORD;
		end else begin
			count <= next_count;
		end
	end

	// Next reload/capture value
	always_comb begin
		next_reload = reload;
		if (trigger_capture) begin
			next_reload = count;
		end
		if (wr_reload_low) begin
			next_reload[7:0] = sfr_wdata_in;
		end
		if (wr_reload_high) begin
			next_reload[15:8] = sfr_wdata_in;
		end
	end

	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			reload <= CRB_RESET_WORD;
		end else begin
			reload <= next_reload;
		end
	end

	// Read mux
	assign control_view = {
		overflow_flag,
		external_edge_flag,
		uart_rx_clock_select,
		uart_tx_clock_select,
		external_trigger_enable,
		run_bit,
		counter_select,
		capture_reload_select
	};

	always_comb begin
		case (sfr_addr_in)
			CRB_ADDR_MODE_CONTROL: begin
				next_rdata = control_view;
			end
			CRB_ADDR_RELOAD_LOW: begin
				next_rdata = reload[7:0];
			end
			CRB_ADDR_RELOAD_HIGH: begin
				next_rdata = reload[15:8];
			end
			CRB_ADDR_COUNT_LOW: begin
				next_rdata = count[7:0];
			end
			CRB_ADDR_COUNT_HIGH: begin
				next_rdata = count[15:8];
			end
			default: begin
				next_rdata = CRB_RESET_BYTE;
			end
		endcase
	end

	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			sfr_rdata_out <= CRB_RESET_BYTE;
		end else if (sfr_rd_in) begin
			sfr_rdata_out <= next_rdata;
		end
	end

	// Interrupt request from either flag
	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			timer_irq_request_out <= 1'b0;
		end else begin
			timer_irq_request_out <= timer_irq_enable_in
				&& (overflow_flag || external_edge_flag);
		end
	end

	// Receive shift clock to the second serial port
	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			uart_rx_shift_tick_out <= 1'b0;
		end else begin
			uart_rx_shift_tick_out <= uart_mode_13_in && (uart_rx_clock_select
				? baud_overflow : other_timer_overflow_in);
		end
	end

	// Transmit shift clock to the second serial port
	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			uart_tx_shift_tick_out <= 1'b0;
		end else begin
			uart_tx_shift_tick_out <= uart_mode_13_in && (uart_tx_clock_select
				? baud_overflow : other_timer_overflow_in);
		end
	end
endmodule

// *** testbench/crb_timer_properties.sv ***
// Purpose: Concurrent checks on register port, interrupt request and shift ticks
// Assumes: Sees only the crb_timer ports
// Notes:   Bound to crb_timer below the module
`timescale 1ns/100ps
module crb_timer_properties
	import crb_pkg::*;
(
	// Clock and reset
	input wire logic       clock_in,
	input wire logic       rst_n_in,
	// Register space
	input wire logic [7:0] sfr_addr_in,
	input wire logic       sfr_wr_in,
	input wire logic       sfr_rd_in,
	input wire logic [7:0] sfr_wdata_in,
	input wire logic [7:0] sfr_rdata_out,
	// Interrupt and serial port clocking
	input wire logic       timer_irq_enable_in,
	input wire logic       timer_irq_request_out,
	input wire logic       uart_mode_13_in,
	input wire logic       other_timer_overflow_in,
	input wire logic       uart_rx_shift_tick_out,
	input wire logic       uart_tx_shift_tick_out
);
	logic       run_shadow;
	logic       mapped;
	logic       any_tick;

	assign mapped = sfr_addr_in == CRB_ADDR_MODE_CONTROL || sfr_addr_in == CRB_ADDR_RELOAD_LOW
		|| sfr_addr_in == CRB_ADDR_RELOAD_HIGH || sfr_addr_in == CRB_ADDR_COUNT_LOW
		|| sfr_addr_in == CRB_ADDR_COUNT_HIGH;
	assign any_tick = uart_rx_shift_tick_out || uart_tx_shift_tick_out;

	// Last run value written by software
	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			run_shadow <= 1'b0;
		end else if (sfr_wr_in && sfr_addr_in == CRB_ADDR_MODE_CONTROL) begin
			run_shadow <= sfr_wdata_in[CRB_BIT_RUN];
		end
	end

	default clocking cb @(posedge clock_in); endclocking
	default disable iff (!rst_n_in);

	a_irq_enable: assert property (
		timer_irq_request_out |-> $past(timer_irq_enable_in))
		else $error("Interrupt request raised while disabled");
	a_irq_persist: assert property (
		$fell(timer_irq_request_out) |-> !$past(timer_irq_enable_in) || $past(sfr_wr_in, 2))
		else $error("Interrupt request dropped without software action");
	a_rdata_hold: assert property (
		!$past(sfr_rd_in) |-> $stable(sfr_rdata_out))
		else $error("Read data changed without a read");
	a_unmapped_zero: assert property (
		sfr_rd_in && !mapped |=> sfr_rdata_out == 8'h00)
		else $error("Unmapped read returned nonzero");
	a_reload_readback: assert property (
		sfr_wr_in && sfr_addr_in == CRB_ADDR_RELOAD_LOW
		##2 sfr_rd_in && sfr_addr_in == CRB_ADDR_RELOAD_LOW
		|=> sfr_rdata_out == $past(sfr_wdata_in, 3))
		else $error("Reload low byte did not read back");
	a_tick_source: assert property (
		any_tick |-> $past(other_timer_overflow_in) || $past(uart_mode_13_in))
		else $error("Shift tick with no source");
	a_tick_single: assert property (
		any_tick && !$past(other_timer_overflow_in) |=> !any_tick)
		else $error("Baud shift tick longer than one cycle");
	a_tick_run: assert property (
		any_tick && !$past(other_timer_overflow_in)
		|-> $past(run_shadow) || $past(run_shadow, 2))
		else $error("Baud shift tick while stopped");

	c_rx_tick: cover property (uart_rx_shift_tick_out);
	c_irq_rise: cover property ($rose(timer_irq_request_out));
	c_unmapped_read: cover property (sfr_rd_in && !mapped);
endmodule

bind crb_timer crb_timer_properties u_props (
	.clock_in(clock_in), .rst_n_in(rst_n_in),
	.sfr_addr_in(sfr_addr_in), .sfr_wr_in(sfr_wr_in), .sfr_rd_in(sfr_rd_in),
	.sfr_wdata_in(sfr_wdata_in), .sfr_rdata_out(sfr_rdata_out),
	.timer_irq_enable_in(timer_irq_enable_in), .timer_irq_request_out(timer_irq_request_out),
	.uart_mode_13_in(uart_mode_13_in), .other_timer_overflow_in(other_timer_overflow_in),
	.uart_rx_shift_tick_out(uart_rx_shift_tick_out),
	.uart_tx_shift_tick_out(uart_tx_shift_tick_out)
);

// *** testbench/crb_pin_model.sv ***
// Purpose: Off-chip sources on the count and trigger pins
// Assumes: Pins pulled high while idle
// Notes:   Each pulse is one clock low, then high again
`timescale 1ns/100ps
module crb_pin_model (
	// Clock
	input  wire logic clock_in,
	// Pins
	output logic      count_pin_out,
	output logic      trigger_pin_out
);
	initial begin
		count_pin_out = 1'b1;
		trigger_pin_out = 1'b1;
	end

	task automatic count_pulses(input int n);
		repeat (n) begin
			@(posedge clock_in);
			#1;
			count_pin_out = 1'b0;
			@(posedge clock_in);
			#1;
			count_pin_out = 1'b1;
		end
	endtask

	task automatic trigger_fall();
		@(posedge clock_in);
		#1;
		trigger_pin_out = 1'b0;
		@(posedge clock_in);
		#1;
		trigger_pin_out = 1'b1;
	endtask
endmodule

// *** testbench/crb_timer_tb_top.sv ***
// Purpose: Self-checking bench for the capture/reload/baud timer
// Assumes: Reset held five cycles, inputs driven 1 ns after edges
// Notes:   Pin events come from crb_pin_model
`timescale 1ns/100ps
module crb_timer_tb_top
	import crb_pkg::*;
;
	logic       clock_in = 1'b0;
	logic       rst_n_in = 1'b0;
	logic [7:0] addr = 8'h00;
	logic       wr = 1'b0;
	logic       rd = 1'b0;
	logic [7:0] wdata = 8'h00;
	logic [7:0] rdata;
	logic       div_sel = 1'b1;
	logic       irq_en = 1'b1;
	logic       irq;
	logic       mode13 = 1'b1;
	logic       other_ovf = 1'b0;
	logic       rx_tick;
	logic       tx_tick;
	logic       count_pin;
	logic       trig_pin;
	int         mismatches = 0;
	int         tests_run = 0;
	int         rx_seen = 0;
	int         tx_seen = 0;

	always #5 clock_in = ~clock_in;
	always @(posedge clock_in) begin
		if (rx_tick === 1'b1) rx_seen++;
		if (tx_tick === 1'b1) tx_seen++;
	end

	crb_timer u_dut (
		.clock_in(clock_in), .rst_n_in(rst_n_in), .sfr_addr_in(addr), .sfr_wr_in(wr),
		.sfr_rd_in(rd), .sfr_wdata_in(wdata), .sfr_rdata_out(rdata),
		.clock_divide_select_in(div_sel), .timer_irq_enable_in(irq_en),
		.timer_irq_request_out(irq), .count_input_pin_in(count_pin),
		.capture_trigger_pin_in(trig_pin), .uart_mode_13_in(mode13),
		.other_timer_overflow_in(other_ovf), .uart_rx_shift_tick_out(rx_tick),
		.uart_tx_shift_tick_out(tx_tick)
	);
	crb_pin_model u_pins (
		.clock_in        (clock_in),
		.count_pin_out   (count_pin),
		.trigger_pin_out (trig_pin)
	);

	task automatic end_of_test();
		$display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_n(input int got, input int exp);
		tests_run++;
		if (got != exp) begin
			mismatches++;
			$display("Error at %0t: %0d ticks, expected %0d", $time, got, exp);
		end
	endtask

	task automatic wr8(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock_in);
		#1;
		addr = a;
		wdata = d;
		wr = 1'b1;
		@(posedge clock_in);
		#1;
		wr = 1'b0;
	endtask

	task automatic rd8(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clock_in);
		#1;
		addr = a;
		rd = 1'b1;
		@(posedge clock_in);
		#1;
		rd = 1'b0;
		chk8(rdata, exp);
	endtask

	task automatic wr16(input logic [7:0] a, input logic [15:0] v);
		wr8(a, v[7:0]);
		wr8(a + 8'h01, v[15:8]);
	endtask

	task automatic rd16(input logic [7:0] a, input logic [15:0] v);
		rd8(a, v[7:0]);
		rd8(a + 8'h01, v[15:8]);
	endtask

	task automatic t_reset_and_map();
		rd8(CRB_ADDR_MODE_CONTROL, 8'h00);
		wr8(CRB_ADDR_RELOAD_LOW, 8'h3c);
		rd8(CRB_ADDR_RELOAD_LOW, 8'h3c);
		wr8(8'h20, 8'h5a);
		rd8(8'h20, 8'h00);
	endtask

	task automatic t_reload_overflow();
		wr16(CRB_ADDR_RELOAD_LOW, 16'h1200);
		wr16(CRB_ADDR_COUNT_LOW, 16'hfff0);
		wr8(CRB_ADDR_MODE_CONTROL, 8'h04);
		repeat (17) @(posedge clock_in);
		rd8(CRB_ADDR_MODE_CONTROL, 8'h84);
		chk8({7'h00, irq}, 8'h01);
		wr8(CRB_ADDR_MODE_CONTROL, 8'h00);
		rd16(CRB_ADDR_COUNT_LOW, 16'h1205);
		chk8({7'h00, irq}, 8'h00);
		div_sel = 1'b0;
		wr16(CRB_ADDR_COUNT_LOW, 16'h0000);
		wr8(CRB_ADDR_MODE_CONTROL, 8'h04);
		repeat (118) @(posedge clock_in);
		wr8(CRB_ADDR_MODE_CONTROL, 8'h00);
		rd16(CRB_ADDR_COUNT_LOW, 16'h000a);
		div_sel = 1'b1;
	endtask

	task automatic t_capture_reload();
		wr16(CRB_ADDR_COUNT_LOW, 16'h00fe);
		wr8(CRB_ADDR_MODE_CONTROL, 8'h07);
		u_pins.count_pulses(3);
		u_pins.trigger_fall();
		rd8(CRB_ADDR_MODE_CONTROL, 8'h07);
		rd16(CRB_ADDR_RELOAD_LOW, 16'h1200);
		rd16(CRB_ADDR_COUNT_LOW, 16'h0101);
		wr8(CRB_ADDR_MODE_CONTROL, 8'h0f);
		u_pins.trigger_fall();
		rd8(CRB_ADDR_MODE_CONTROL, 8'h4f);
		rd16(CRB_ADDR_RELOAD_LOW, 16'h0101);
		wr16(CRB_ADDR_RELOAD_LOW, 16'hab00);
		wr8(CRB_ADDR_MODE_CONTROL, 8'h0e);
		u_pins.trigger_fall();
		rd16(CRB_ADDR_COUNT_LOW, 16'hab00);
		rd8(CRB_ADDR_MODE_CONTROL, 8'h4e);
	endtask

	task automatic t_baud();
		int r0;
		int t0;
		wr16(CRB_ADDR_RELOAD_LOW, 16'hfff0);
		wr16(CRB_ADDR_COUNT_LOW, 16'hfff1);
		r0 = rx_seen;
		t0 = tx_seen;
		wr8(CRB_ADDR_MODE_CONTROL, 8'h35);
		repeat (316) @(posedge clock_in);
		rd8(CRB_ADDR_MODE_CONTROL, 8'h35);
		wr8(CRB_ADDR_MODE_CONTROL, 8'h00);
		repeat (2) @(posedge clock_in);
		#1;
		chk_n(rx_seen - r0, 10);
		chk_n(tx_seen - t0, 10);
		rd16(CRB_ADDR_COUNT_LOW, 16'hfff1);
		wr16(CRB_ADDR_COUNT_LOW, 16'hfffe);
		r0 = rx_seen;
		t0 = tx_seen;
		wr8(CRB_ADDR_MODE_CONTROL, 8'h36);
		u_pins.count_pulses(3);
		wr8(CRB_ADDR_MODE_CONTROL, 8'h00);
		repeat (2) @(posedge clock_in);
		#1;
		chk_n(rx_seen - r0, 1);
		chk_n(tx_seen - t0, 1);
		rd16(CRB_ADDR_COUNT_LOW, 16'hfff1);
		r0 = rx_seen;
		t0 = tx_seen;
		repeat (3) begin
			@(posedge clock_in);
			#1;
			other_ovf = 1'b1;
			@(posedge clock_in);
			#1;
			other_ovf = 1'b0;
		end
		repeat (2) @(posedge clock_in);
		#1;
		chk_n(rx_seen - r0, 3);
		chk_n(tx_seen - t0, 3);
		mode13 = 1'b0;
		r0 = rx_seen;
		wr8(CRB_ADDR_MODE_CONTROL, 8'h35);
		repeat (100) @(posedge clock_in);
		wr8(CRB_ADDR_MODE_CONTROL, 8'h3c);
		u_pins.trigger_fall();
		rd8(CRB_ADDR_MODE_CONTROL, 8'h7c);
		chk_n(rx_seen - r0, 0);
		chk8({7'h00, irq}, 8'h01);
		irq_en = 1'b0;
		repeat (2) @(posedge clock_in);
		chk8({7'h00, irq}, 8'h00);
		wr8(CRB_ADDR_MODE_CONTROL, 8'h00);
		mode13 = 1'b1;
	endtask

	initial begin
		#100000;
		mismatches++;
		end_of_test();
	end

	initial begin
		repeat (5) @(posedge clock_in);
		#1;
		rst_n_in = 1'b1;
		t_reset_and_map();
		t_reload_overflow();
		t_capture_reload();
		t_baud();
		end_of_test();
	end
endmodule
